// >>> hdl/fp_sst_pkg.sv
/*
  Shared constants, types and encodings for the floating-point subtract,
  word store and truncate-to-long decoder. Assumes a 64-bit register view.
*/
package fp_sst_pkg;

  // Major and function opcodes
  localparam logic [5:0] OP_FP_COPROC = 6'h11;
  localparam logic [5:0] OP_FP_XFORM = 6'h13;
  localparam logic [5:0] OP_FP_WORD_STORE = 6'h39;
  localparam logic [5:0] FN_SUB = 6'h01;
  localparam logic [5:0] FN_CHOP_LONG = 6'h09;
  localparam logic [5:0] FN_STORE_INDEXED = 6'h08;

  // Operand formats
  localparam logic [4:0] FMT_SINGLE = 5'h10;
  localparam logic [4:0] FMT_DOUBLE = 5'h11;

  // Rounding mode forced by truncation
  localparam logic [1:0] RM_TOWARD_ZERO = 2'h1;

  // Results and exponent handling
  localparam logic [63:0] LONG_DEFAULT = 64'h7FFF_FFFF_FFFF_FFFF;
  localparam logic [63:0] LONG_MIN = 64'h8000_0000_0000_0000;
  localparam logic [10:0] DBL_BIAS = 11'h3FF;
  localparam logic [10:0] SGL_TO_DBL = 11'h380;
  localparam logic [10:0] EXP_ALL_ONES = 11'h7FF;
  localparam logic [5:0] FRAC_BITS = 6'h34;

  // Flag bit positions
  localparam int FLG_INEXACT = 0;
  localparam int FLG_UNDERFLOW = 1;
  localparam int FLG_OVERFLOW = 2;
  localparam int FLG_INVALID = 3;
  localparam int FLG_UNIMPL = 4;

  localparam int PADDR_W = 36;

  typedef enum logic [3:0] {
    EXC_NONE,
    EXC_COP_UNUSABLE,
    EXC_RESERVED,
    EXC_ADDR_ERROR,
    EXC_TLB_REFILL,
    EXC_TLB_INVALID,
    EXC_TLB_MODIFIED,
    EXC_FP_PRECISE,
    EXC_FP_IMPRECISE
  } exc_e;

  typedef struct packed {
    logic [31:0] instr;
    logic [63:0] first_source;
    logic [63:0] second_source;
    logic [63:0] base;
    logic [63:0] index;
  } issue_s;

  typedef struct packed {
    logic imprecise;
    logic [4:0] enables;
    logic [1:0] round_mode;
  } fp_control_status_reg_s;

  typedef struct packed {
    logic valid;
    logic [63:0] value;
    logic [4:0] flags;
  } sub_result_s;

  typedef struct packed {
    logic valid;
    logic [PADDR_W-1:0] paddr;
    logic refill;
    logic invalid;
    logic modified;
  } xlate_s;

  typedef struct packed {
    logic [63:0] value;
    logic invalid;
    logic inexact;
  } chop_s;

endpackage

// >>> hdl/fp_subtract_store_truncate.sv
/*
  Decode and execute control for the FP subtract, the two FP word stores
  and the FP truncate-to-long. Operand values come with the issued
  instruction; the subtract arithmetic and address translation are
  external units reached by request/response ports.
*/
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - Decode subtract by opcode and function
// - Difference first minus second, rounded, written back
// - Subtract raises coprocessor, reserved and FP exceptions
// - Decode offset word store, store low word
// - Address is base plus sign-extended offset
// - Misaligned store address: address error, no store
// - 64-bit mode: endian XOR on address, word lane placement
// - Indexed store: base plus index address
// - Stores raise TLB, address, unusable; never reserved
// - Decode truncate-to-long, middle field must be zero
// - Truncate toward zero into 64-bit integer
// - Infinity, NaN or out of range is invalid
// - Invalid handling follows active exception model
// - Precise: set flag, trap or write default
// - Imprecise: write default, later trap if enabled
module fp_subtract_store_truncate (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Issue side
  input wire logic issue_valid_i,
  input wire fp_sst_pkg::issue_s issue_i,
  output logic busy_o,
  // Processor state
  input wire fp_sst_pkg::fp_control_status_reg_s fp_control_status_reg_i,
  input wire logic fp_coprocessor_opcode_usable_i,
  input wire logic mode64_i,
  input wire logic big_endian_core_i,
  input wire logic flip_byte_order_flag_i,
  // Subtract unit
  output logic sub_req_o,
  output logic [63:0] sub_a_o,
  output logic [63:0] sub_b_o,
  output logic sub_double_o,
  output logic [1:0] sub_round_o,
  input wire fp_sst_pkg::sub_result_s sub_res_i,
  // Address translation
  output logic xlate_req_o,
  output logic [63:0] xlate_vaddr_o,
  input wire fp_sst_pkg::xlate_s xlate_i,
  // Memory store path
  output logic store_valid_o,
  output logic [fp_sst_pkg::PADDR_W-1:0] store_paddr_o,
  output logic [63:0] store_vaddr_o,
  output logic [63:0] store_data_o,
  output logic [7:0] store_lanes_o,
  // Register write and status
  output logic fpr_we_o,
  output logic [4:0] dest_fp_reg_o,
  output logic [63:0] fpr_wdata_o,
  output logic [4:0] flag_set_o,
  output logic exc_valid_o,
  output fp_sst_pkg::exc_e exc_code_o
);

  typedef enum logic [1:0] {IDLE, SUB_WAIT, XLATE_WAIT} state_e;

  function automatic logic [63:0] add64(input logic [63:0] a,
                                       input logic [63:0] b);
    add64 = a + b;
  endfunction

  function automatic fp_sst_pkg::chop_s chop(input logic dbl,
                                             input logic [63:0] v);
    logic sgn;
    logic [10:0] ex;
    logic [51:0] fr;
    logic [63:0] mag;
    logic [5:0] sh;
    fp_sst_pkg::chop_s r;
    r = '0;
    mag = {12'h001, v[51:0]};
    sh = 6'h00;
    if (dbl)
    begin
      sgn = v[63];
      ex = v[62:52];
      fr = v[51:0];
    end
    else
    begin
      sgn = v[31];
      fr = {v[22:0], 29'h0000_0000};
      if (v[30:23] == 8'hFF)
        ex = fp_sst_pkg::EXP_ALL_ONES;
      else if (v[30:23] == 8'h00)
        ex = 11'h000;
      else
        ex = {3'h0, v[30:23]} + fp_sst_pkg::SGL_TO_DBL;
    end
    mag = {12'h001, fr};
    if (ex == fp_sst_pkg::EXP_ALL_ONES)
      r.invalid = 1'b1;
    else if (ex < fp_sst_pkg::DBL_BIAS)
      r.inexact = (ex != 11'h000) || (fr != 52'h0_0000_0000_0000);
    else if (ex >= fp_sst_pkg::DBL_BIAS + 11'd63)
    begin
      // Only -2^63 itself fits at this exponent
      if (sgn && ex == fp_sst_pkg::DBL_BIAS + 11'd63 &&
          fr == 52'h0_0000_0000_0000)
        r.value = fp_sst_pkg::LONG_MIN;
      else
        r.invalid = 1'b1;
    end
    else
    begin
      sh = 6'(ex - fp_sst_pkg::DBL_BIAS);
      if (sh >= fp_sst_pkg::FRAC_BITS)
        mag = mag << (sh - fp_sst_pkg::FRAC_BITS);
      else
      begin
        // Discarded fraction bits: chop toward zero, flag inexact
        r.inexact = (fr & ~(52'hF_FFFF_FFFF_FFFF <<
                     (fp_sst_pkg::FRAC_BITS - sh))) != 52'h0;
        mag = mag >> (fp_sst_pkg::FRAC_BITS - sh);
      end
      r.value = sgn ? (64'h0000_0000_0000_0000 - mag) : mag;
    end
    return r;
  endfunction

  state_e state;
  logic [63:0] held_vaddr;
  logic [31:0] held_word;
  logic [4:0] held_dest;
  logic pend_imprecise;

  // Field decode
  wire logic [5:0] major = issue_i.instr[31:26];
  wire logic [4:0] fmt_f = issue_i.instr[25:21];
  wire logic [4:0] mid_f = issue_i.instr[20:16];
  wire logic [4:0] src_f = issue_i.instr[15:11];
  wire logic [4:0] dst_f = issue_i.instr[10:6];
  wire logic [5:0] func = issue_i.instr[5:0];
  wire logic fmt_ok = (fmt_f == fp_sst_pkg::FMT_SINGLE) ||
                      (fmt_f == fp_sst_pkg::FMT_DOUBLE);
  wire logic is_dbl = (fmt_f == fp_sst_pkg::FMT_DOUBLE);

  wire logic take = issue_valid_i && !busy_o;
  wire logic hit_sub = (major == fp_sst_pkg::OP_FP_COPROC) &&
                       (func == fp_sst_pkg::FN_SUB);
  wire logic hit_chop = (major == fp_sst_pkg::OP_FP_COPROC) &&
                        (func == fp_sst_pkg::FN_CHOP_LONG);
  wire logic hit_st = (major == fp_sst_pkg::OP_FP_WORD_STORE);
  wire logic hit_stx = (major == fp_sst_pkg::OP_FP_XFORM) &&
                       (func == fp_sst_pkg::FN_STORE_INDEXED);
  wire logic hit_any = hit_sub || hit_chop || hit_st || hit_stx;
  wire logic bad_enc = ((hit_sub || hit_chop) && !fmt_ok) ||
                       (hit_chop && mid_f != 5'h00);

  // Address and store word
  wire logic [63:0] offs_ext = {{48{issue_i.instr[15]}},
                                issue_i.instr[15:0]};
  // Region bits of an indexed address are trusted to come from base
  wire logic [63:0] eff_addr = hit_st ?
    add64(issue_i.base, offs_ext) :
    add64(issue_i.base, issue_i.index);
  wire logic misaligned = eff_addr[1:0] != 2'b00;
  wire logic [31:0] store_word = issue_i.first_source[31:0];

  // Truncation
  wire fp_sst_pkg::chop_s chop_r = chop(is_dbl, issue_i.first_source);
  wire logic inv_trap = fp_control_status_reg_i.enables[fp_sst_pkg::FLG_INVALID];

  // Lane placement for the translated store
  wire logic upper_half = held_vaddr[2] ^ big_endian_core_i;
  wire logic [2:0] pa_low = xlate_i.paddr[2:0] ^
                            {flip_byte_order_flag_i, 2'b00};
  wire logic xlate_fault = xlate_i.refill || xlate_i.invalid ||
                           xlate_i.modified;
  wire fp_sst_pkg::exc_e xlate_code =
    xlate_i.refill ? fp_sst_pkg::EXC_TLB_REFILL :
    xlate_i.invalid ? fp_sst_pkg::EXC_TLB_INVALID :
    fp_sst_pkg::EXC_TLB_MODIFIED;

  // Subtract result trap: unimplemented always traps
  wire logic [4:0] sub_trap_mask = sub_res_i.flags &
    (fp_control_status_reg_i.enables | (5'h01 << fp_sst_pkg::FLG_UNIMPL));

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state <= IDLE;
      busy_o <= 1'b0;
      held_vaddr <= 64'h0000_0000_0000_0000;
      held_word <= 32'h0000_0000;
      held_dest <= 5'h00;
      pend_imprecise <= 1'b0;
      sub_req_o <= 1'b0;
      sub_a_o <= 64'h0000_0000_0000_0000;
      sub_b_o <= 64'h0000_0000_0000_0000;
      sub_double_o <= 1'b0;
      sub_round_o <= 2'h0;
      xlate_req_o <= 1'b0;
      xlate_vaddr_o <= 64'h0000_0000_0000_0000;
      store_valid_o <= 1'b0;
      store_paddr_o <= '0;
      store_vaddr_o <= 64'h0000_0000_0000_0000;
      store_data_o <= 64'h0000_0000_0000_0000;
      store_lanes_o <= 8'h00;
      fpr_we_o <= 1'b0;
      dest_fp_reg_o <= 5'h00;
      fpr_wdata_o <= 64'h0000_0000_0000_0000;
      flag_set_o <= 5'h00;
      exc_valid_o <= 1'b0;
      exc_code_o <= fp_sst_pkg::EXC_NONE;
    end
    else
    begin
      sub_req_o <= 1'b0;
      xlate_req_o <= 1'b0;
      store_valid_o <= 1'b0;
      fpr_we_o <= 1'b0;
      flag_set_o <= 5'h00;
      exc_valid_o <= 1'b0;
      exc_code_o <= fp_sst_pkg::EXC_NONE;
      // A deferred invalid trap goes out on the first quiet cycle
      if (pend_imprecise && state == IDLE && !(take && hit_any))
      begin
        pend_imprecise <= 1'b0;
        exc_valid_o <= 1'b1;
        exc_code_o <= fp_sst_pkg::EXC_FP_IMPRECISE;
      end
      case (state)
        IDLE:
        begin
          if (take && hit_any)
          begin
            if (!fp_coprocessor_opcode_usable_i)
            begin
              exc_valid_o <= 1'b1;
              exc_code_o <= fp_sst_pkg::EXC_COP_UNUSABLE;
            end
            else if (bad_enc)
            begin
              exc_valid_o <= 1'b1;
              exc_code_o <= fp_sst_pkg::EXC_RESERVED;
            end
            else if (hit_sub)
            begin
              sub_req_o <= 1'b1;
              sub_a_o <= issue_i.first_source;
              sub_b_o <= issue_i.second_source;
              sub_double_o <= is_dbl;
              sub_round_o <= fp_control_status_reg_i.round_mode;
              held_dest <= dst_f;
              state <= SUB_WAIT;
              busy_o <= 1'b1;
            end
            else if (hit_chop)
            begin
              dest_fp_reg_o <= dst_f;
              if (!chop_r.invalid)
              begin
                fpr_we_o <= 1'b1;
                fpr_wdata_o <= chop_r.value;
                flag_set_o <= {4'h0, chop_r.inexact};
              end
              else if (!fp_control_status_reg_i.imprecise)
              begin
                flag_set_o <= 5'h01 << fp_sst_pkg::FLG_INVALID;
                fpr_we_o <= !inv_trap;
                fpr_wdata_o <= fp_sst_pkg::LONG_DEFAULT;
                exc_valid_o <= inv_trap;
                exc_code_o <= inv_trap ? fp_sst_pkg::EXC_FP_PRECISE :
                              fp_sst_pkg::EXC_NONE;
              end
              else
              begin
                fpr_we_o <= 1'b1;
                fpr_wdata_o <= fp_sst_pkg::LONG_DEFAULT;
                pend_imprecise <= pend_imprecise || inv_trap;
              end
            end
            else if (misaligned)
            begin
              exc_valid_o <= 1'b1;
              exc_code_o <= fp_sst_pkg::EXC_ADDR_ERROR;
            end
            else
            begin
              xlate_req_o <= 1'b1;
              xlate_vaddr_o <= eff_addr;
              held_vaddr <= eff_addr;
              held_word <= hit_st ? issue_i.second_source[31:0] :
                           store_word;
              state <= XLATE_WAIT;
              busy_o <= 1'b1;
            end
          end
        end
        SUB_WAIT:
        begin
          if (sub_res_i.valid)
          begin
            flag_set_o <= sub_res_i.flags;
            dest_fp_reg_o <= held_dest;
            fpr_wdata_o <= sub_res_i.value;
            fpr_we_o <= sub_trap_mask == 5'h00;
            exc_valid_o <= sub_trap_mask != 5'h00;
            exc_code_o <= (sub_trap_mask != 5'h00) ?
                          fp_sst_pkg::EXC_FP_PRECISE :
                          fp_sst_pkg::EXC_NONE;
            state <= IDLE;
            busy_o <= 1'b0;
          end
        end
        XLATE_WAIT:
        begin
          if (xlate_i.valid)
          begin
            if (xlate_fault)
            begin
              exc_valid_o <= 1'b1;
              exc_code_o <= xlate_code;
            end
            else
            begin
              store_valid_o <= 1'b1;
              store_vaddr_o <= held_vaddr;
              if (mode64_i)
              begin
                store_paddr_o <= {xlate_i.paddr[fp_sst_pkg::PADDR_W-1:3],
                                  pa_low};
                store_data_o <= upper_half ? {held_word, 32'h0000_0000} :
                                {32'h0000_0000, held_word};
                store_lanes_o <= upper_half ? 8'hF0 : 8'h0F;
              end
              else
              begin
                store_paddr_o <= xlate_i.paddr;
                store_data_o <= {32'h0000_0000, held_word};
                store_lanes_o <= 8'h0F;
              end
            end
            state <= IDLE;
            busy_o <= 1'b0;
          end
        end
        default:
        begin
          state <= IDLE;
          busy_o <= 1'b0;
        end
      endcase
    end
  end

endmodule // fp_subtract_store_truncate

`default_nettype wire

// >>> dv/fp_sst_chk.sv
/*
  Port checker for the FP subtract, word store and truncate decoder.
  Assumes the top module's port names; bound to every instance of it.
*/
`timescale 1ns/1ns
`default_nettype none
module fp_sst_chk (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Issue and state
  input wire logic issue_valid_i,
  input wire fp_sst_pkg::issue_s issue_i,
  input wire logic busy_o,
  input wire logic fp_coprocessor_opcode_usable_i,
  input wire logic mode64_i,
  input wire logic big_endian_core_i,
  // Far side answers
  input wire fp_sst_pkg::sub_result_s sub_res_i,
  input wire fp_sst_pkg::xlate_s xlate_i,
  // Outputs
  input wire logic sub_req_o,
  input wire logic xlate_req_o,
  input wire logic [63:0] xlate_vaddr_o,
  input wire logic store_valid_o,
  input wire logic [63:0] store_vaddr_o,
  input wire logic [7:0] store_lanes_o,
  input wire logic fpr_we_o,
  input wire logic [4:0] flag_set_o,
  input wire logic exc_valid_o,
  input wire fp_sst_pkg::exc_e exc_code_o
);
  wire logic [31:0] ins = issue_i.instr;
  wire logic cop = ins[31:26] == fp_sst_pkg::OP_FP_COPROC;
  wire logic is_sub = cop && ins[5:0] == fp_sst_pkg::FN_SUB;
  wire logic is_chop = cop && ins[5:0] == fp_sst_pkg::FN_CHOP_LONG
    && ins[20:16] == 5'h00;
  wire logic is_sto = ins[31:26] == fp_sst_pkg::OP_FP_WORD_STORE;
  wire logic is_stx = ins[31:26] == fp_sst_pkg::OP_FP_XFORM
    && ins[5:0] == fp_sst_pkg::FN_STORE_INDEXED;
  wire logic fmt_ok = ins[25:21] == fp_sst_pkg::FMT_SINGLE
    || ins[25:21] == fp_sst_pkg::FMT_DOUBLE;
  wire logic go = issue_valid_i && !busy_o;
  wire logic [63:0] ea = is_stx ? issue_i.base + issue_i.index
    : issue_i.base + {{48{ins[15]}}, ins[15:0]};

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_arith;
    go && fp_coprocessor_opcode_usable_i && fmt_ok;
  endsequence
  sequence s_store;
    go && fp_coprocessor_opcode_usable_i && (is_sto || is_stx);
  endsequence

  a_sub_request:
    assert property (s_arith ##0 is_sub |=> sub_req_o && busy_o)
    else $error("subtract not sent to the unit");
  a_chop_answer:
    assert property (s_arith ##0 is_chop
      |=> !busy_o && (fpr_we_o || exc_valid_o))
    else $error("truncate gave no answer");
  a_bad_format:
    assert property (go && fp_coprocessor_opcode_usable_i && !fmt_ok && (is_sub || is_chop)
      |=> exc_valid_o && exc_code_o == fp_sst_pkg::EXC_RESERVED)
    else $error("bad format not refused");
  a_unusable_first:
    assert property (go && !fp_coprocessor_opcode_usable_i && (is_sto || is_stx)
      |=> exc_valid_o && exc_code_o == fp_sst_pkg::EXC_COP_UNUSABLE)
    else $error("unusable store not refused");
  a_misalign_stop:
    assert property (s_store ##0 ea[1:0] != 2'h0
      |=> exc_code_o == fp_sst_pkg::EXC_ADDR_ERROR && !xlate_req_o
      ##1 !store_valid_o)
    else $error("misaligned store not stopped");
  a_store_addr:
    assert property (s_store ##0 ea[1:0] == 2'h0
      |=> xlate_req_o && xlate_vaddr_o == $past(ea))
    else $error("wrong store address");
  a_sub_finish:
    assert property (sub_res_i.valid && busy_o |=> !busy_o
      && flag_set_o == $past(sub_res_i.flags)
      && (fpr_we_o || exc_code_o == fp_sst_pkg::EXC_FP_PRECISE))
    else $error("subtract result mishandled");
  a_xlate_finish:
    assert property (xlate_i.valid && busy_o
      |=> !busy_o && (store_valid_o ^ exc_valid_o))
    else $error("translation answer mishandled");
  a_lane_select:
    assert property (store_valid_o && mode64_i |-> store_lanes_o
      == (store_vaddr_o[2] ^ big_endian_core_i ? 8'hF0 : 8'h0F))
    else $error("wrong store lanes");
endmodule // fp_sst_chk

bind fp_subtract_store_truncate fp_sst_chk chk_u (.*);
`default_nettype wire

// >>> dv/fp_sst_far_model.sv
/*
  Model of the subtract unit and address translation facing the decoder.
  Assumes one request outstanding at a time; delay and faults from bench.
*/
`timescale 1ns/1ns
`default_nettype none
module fp_sst_far_model (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Bench controls
  input wire logic [2:0] delay_i,
  input wire logic [4:0] flags_i,
  input wire logic [2:0] tlb_i,
  // Requests
  input wire logic sub_req_i,
  input wire logic [63:0] sub_a_i,
  input wire logic [63:0] sub_b_i,
  input wire logic xlate_req_i,
  input wire logic [63:0] xlate_vaddr_i,
  // Answers
  output fp_sst_pkg::sub_result_s sub_res_o,
  output fp_sst_pkg::xlate_s xlate_o
);
  logic [2:0] cnt;
  logic sub_wait;
  logic xl_wait;
  logic [63:0] diff;
  logic [35:0] pa;
  wire logic fire = cnt == 3'h0;
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      cnt <= 3'h0;
      sub_wait <= 1'b0;
      xl_wait <= 1'b0;
    end
    else
    begin
      cnt <= (sub_req_i || xlate_req_i) ? delay_i : cnt - 3'h1;
      sub_wait <= sub_req_i || (sub_wait && !fire);
      xl_wait <= xlate_req_i || (xl_wait && !fire);
    end
  end
  // Integer difference stands in for the float arithmetic
  always_ff @(posedge core_clk_i)
  begin
    diff <= sub_req_i ? sub_a_i - sub_b_i : diff;
    pa <= xlate_req_i ? xlate_vaddr_i[35:0] : pa;
  end
  // Outside the answer cycle the lines carry junk, not the last value
  assign sub_res_o = (sub_wait && fire) ? {1'b1, diff, flags_i}
    : {1'b0, ~diff, ~flags_i};
  assign xlate_o = (xl_wait && fire) ? {1'b1, pa, tlb_i}
    : {1'b0, ~pa, ~tlb_i};
endmodule // fp_sst_far_model
`default_nettype wire

// >>> dv/fp_subtract_store_truncate_tb_top.sv
/*
  Random self-checking bench for the FP decoder with corner values.
  Assumes the far-side model answers each request once.
*/
`timescale 1ns/1ns
`default_nettype none
module fp_subtract_store_truncate_tb_top;
  logic core_clk_i, sys_rst_i, issue_valid_i, fp_coprocessor_opcode_usable_i, mode64_i;
  logic big_endian_core_i, flip_byte_order_flag_i, busy_o, sub_req_o;
  logic sub_double_o, xlate_req_o, store_valid_o, fpr_we_o, exc_valid_o;
  logic [63:0] sub_a_o, sub_b_o, xlate_vaddr_o, store_vaddr_o;
  logic [63:0] store_data_o, fpr_wdata_o, a, b, bs, ix, ea, wd, dd;
  logic [35:0] store_paddr_o, pa;
  logic [7:0] store_lanes_o;
  logic [4:0] dest_fp_reg_o, flag_set_o, flags, fm;
  logic [2:0] delay, tlb;
  logic [1:0] sub_round_o;
  logic [31:0] ins;
  logic [15:0] off;
  logic [64:0] r;
  logic we, st, bad, imp, hi, go;
  int n_errors, samples_checked, k, n, seen;
  fp_sst_pkg::issue_s issue_i;
  fp_sst_pkg::fp_control_status_reg_s fp_control_status_reg_i;
  fp_sst_pkg::sub_result_s sub_res_i;
  fp_sst_pkg::xlate_s xlate_i;
  fp_sst_pkg::exc_e exc_code_o, ex;
  logic [63:0] corners [0:6] = '{64'h7FF0_0000_0000_0000,
    64'h7FF8_0000_0000_0001, 64'h43E0_0000_0000_0000,
    64'hC3E0_0000_0000_0000, 64'h3FF8_0000_0000_0000,
    64'hBFE0_0000_0000_0000, 64'h43DF_FFFF_FFFF_FFFF};

  fp_subtract_store_truncate dut_u (.*);
  fp_sst_far_model far_u (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .delay_i(delay), .flags_i(flags), .tlb_i(tlb), .sub_req_i(sub_req_o),
    .sub_a_i(sub_a_o), .sub_b_i(sub_b_o), .xlate_req_i(xlate_req_o),
    .xlate_vaddr_i(xlate_vaddr_o), .sub_res_o(sub_res_i), .xlate_o(xlate_i));

  task automatic chk(string s, logic [63:0] e, logic [63:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic tick();
    @(posedge core_clk_i);
    #1;
  endtask
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Truncation of a double: invalid bit on top, then the 64-bit value
  function automatic logic [64:0] trunc(logic [63:0] d);
    int e;
    logic [63:0] m;
    e = int'(d[62:52]) - 1023;
    m = {12'h001, d[51:0]};
    if (e > 63 || (e == 63 && !(d[63] && d[51:0] == 52'h0)))
      return {1'b1, fp_sst_pkg::LONG_DEFAULT};
    if (e < 0)
      return 65'h0;
    m = e >= 52 ? m << (e - 52) : m >> (52 - e);
    return {1'b0, d[63] ? -m : m};
  endfunction

  initial
  begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  initial
  begin
    #3_000_000;
    n_errors++;
    summarize();
  end
  initial
  begin
    {sys_rst_i, fp_coprocessor_opcode_usable_i, mode64_i} = 3'h7;
    {issue_valid_i, big_endian_core_i, flip_byte_order_flag_i} = 3'h0;
    {issue_i, fp_control_status_reg_i, delay, flags, tlb} = '0;
    void'($urandom(32'h5399_c478));
    repeat (6) tick();
    chk("reset", 64'h0, {busy_o, sub_req_o, xlate_req_o, fpr_we_o});
    sys_rst_i = 1'b0;
    for (int i = 0; i < 400; i++)
    begin
      k = $urandom % 4;
      {a, b, bs} = {$urandom, $urandom, $urandom, $urandom, $urandom,
        $urandom};
      bs[1:0] = ($urandom % 4 == 0) ? 2'($urandom) : 2'h0;
      ix = {44'h0, 18'($urandom), 2'h0};
      off = {14'($urandom), 2'h0};
      fp_control_status_reg_i = 8'($urandom);
      {fp_coprocessor_opcode_usable_i, mode64_i, big_endian_core_i} = 3'($urandom | 4);
      fp_coprocessor_opcode_usable_i = ($urandom % 8) != 0;
      flip_byte_order_flag_i = 1'($urandom);
      delay = 3'($urandom);
      flags = ($urandom % 3 == 0) ? 5'($urandom) : 5'h00;
      tlb = ($urandom % 3 == 0) ? 3'($urandom) : 3'h0;
      fm = ($urandom % 2) ? fp_sst_pkg::FMT_DOUBLE : fp_sst_pkg::FMT_SINGLE;
      fm = ($urandom % 8 == 0) ? 5'h14 : fm;
      if (k == 1 && fm == fp_sst_pkg::FMT_DOUBLE)
        a = ($urandom % 3 == 0) ? corners[$urandom % 7] : {1'($urandom),
          11'(11'h3FD + $urandom % 72), a[51:0]};
      if (k == 1 && fm == fp_sst_pkg::FMT_SINGLE)
        a = 64'h0000_0000_C060_0000;
      case (k)
        0: ins = {fp_sst_pkg::OP_FP_COPROC, fm, 15'($urandom),
          fp_sst_pkg::FN_SUB};
        1: ins = {fp_sst_pkg::OP_FP_COPROC, fm, ($urandom % 8 == 0) ? 5'h01
          : 5'h00, 10'($urandom), fp_sst_pkg::FN_CHOP_LONG};
        2: ins = {fp_sst_pkg::OP_FP_WORD_STORE, 10'($urandom), off};
        default: ins = {fp_sst_pkg::OP_FP_XFORM, 15'($urandom), 5'h00,
          fp_sst_pkg::FN_STORE_INDEXED};
      endcase
      ea = k == 2 ? bs + {{48{off[15]}}, off} : bs + ix;
      bad = k < 2 && (fm == 5'h14 || (k == 1 && ins[20:16] != 5'h00));
      r = fm == fp_sst_pkg::FMT_SINGLE ? {1'b0, -64'h3} : trunc(a);
      {we, st, imp, wd} = '0;
      ex = fp_sst_pkg::EXC_NONE;
      if (!fp_coprocessor_opcode_usable_i)
        ex = fp_sst_pkg::EXC_COP_UNUSABLE;
      else if (bad)
        ex = fp_sst_pkg::EXC_RESERVED;
      else if (k == 0)
      begin
        we = (flags & (fp_control_status_reg_i.enables | 5'h10)) == 5'h00;
        wd = a - b;
      end
      else if (k == 1)
      begin
        we = !(r[64] && !fp_control_status_reg_i.imprecise && fp_control_status_reg_i.enables[3]);
        wd = r[63:0];
        imp = r[64] && fp_control_status_reg_i.imprecise && fp_control_status_reg_i.enables[3];
      end
      else if (ea[1:0] != 2'h0)
        ex = fp_sst_pkg::EXC_ADDR_ERROR;
      else if (tlb != 3'h0)
        ex = tlb[2] ? fp_sst_pkg::EXC_TLB_REFILL : tlb[1]
          ? fp_sst_pkg::EXC_TLB_INVALID : fp_sst_pkg::EXC_TLB_MODIFIED;
      else
        st = 1'b1;
      if (k < 2 && ex == fp_sst_pkg::EXC_NONE && !we)
        ex = fp_sst_pkg::EXC_FP_PRECISE;
      issue_i = {ins, a, b, bs, ix};
      issue_valid_i = 1'b1;
      tick();
      issue_valid_i = 1'b0;
      go = k == 0 && fp_coprocessor_opcode_usable_i && !bad;
      chk("sub_req", go, sub_req_o);
      dd = {61'h0, fm == fp_sst_pkg::FMT_DOUBLE, fp_control_status_reg_i.round_mode};
      if (go)
      begin
        chk("sub_a", a, sub_a_o);
        chk("sub_b", b, sub_b_o);
        chk("sub_ctl", dd, {sub_double_o, sub_round_o});
      end
      for (n = 0; n < 30 && !(fpr_we_o | exc_valid_o | store_valid_o); n++)
        tick();
      chk("write", we, fpr_we_o);
      chk("exception", ex, exc_code_o);
      chk("store", st, store_valid_o);
      if (we)
        chk("wdata", wd, fpr_wdata_o);
      if (we)
        chk("dest", ins[10:6], dest_fp_reg_o);
      if (k == 0 && fp_coprocessor_opcode_usable_i && !bad)
        chk("flags", flags, flag_set_o);
      if (k == 1 && fp_coprocessor_opcode_usable_i && !bad)
        chk("invalid", r[64] && !fp_control_status_reg_i.imprecise,
          flag_set_o[fp_sst_pkg::FLG_INVALID]);
      pa = ea[35:0] ^ {33'h0, mode64_i & flip_byte_order_flag_i, 2'h0};
      hi = mode64_i && (ea[2] ^ big_endian_core_i);
      dd = hi ? {k == 2 ? b[31:0] : a[31:0], 32'h0}
        : {32'h0, k == 2 ? b[31:0] : a[31:0]};
      if (st)
        chk("paddr", {pa, 28'h0}, {store_paddr_o, 28'h0});
      if (st)
        chk("sdata", dd, store_data_o);
      if (st)
        chk("lanes", hi ? 8'hF0 : 8'h0F, store_lanes_o);
      if (st)
        chk("svaddr", ea, store_vaddr_o);
      seen = 0;
      repeat (3)
      begin
        tick();
        seen += exc_valid_o === 1'b1
          && exc_code_o === fp_sst_pkg::EXC_FP_IMPRECISE;
      end
      chk("late_trap", imp, seen);
    end
    summarize();
  end
endmodule // fp_subtract_store_truncate_tb_top
`default_nettype wire
